/* hw/rpd_pkg.sv */
/*
  Constants, types and register map of the reset, idle and power-down
  controller. Assumes one 10 MHz oscillator clock and a byte-wide
  register port driven by the CPU side.
*/
// Functional notes
// - Inverted external pin levels latch into request flags at phase nine.
// - Timer A/B overflow flags set at phase nine, polled next cycle.
// - Timer C overflow flag set at phase three, polled same cycle.
// - Accepted request issues a two-cycle hardware call as next instruction.
// - Unfinished instruction adds at most three cycles of wait.
// - Return or enable/priority access adds at most five cycles of wait.
// - Single-source latency stays above three and below nine cycles.
// - No service during equal-level routine; one instruction after return.
// - Reset pin sampled each cycle; internal reset 19 periods after.
// - Internal reset zeroes registers; ports FF, stack pointer 07.
// - Reset leaves internal RAM untouched.
// - Idle starts right after the idle write; CPU clock gated off.
// - In idle CPU state and ports hold; both strobes stay high.
// - Enabled interrupt clears idle bit and is then serviced.
// - Two general flag bits in the power control register.
// - Reset pin clears idle bit at once, before internal reset.
// - Between reset idle exit and internal reset, RAM access blocked.
// - Power-down write stops oscillator; ports hold; both strobes low.
// - Only reset leaves power-down; it restarts the oscillator.
// - Call withheld for level in progress, non-final cycle, return, IE/IP.
package rpd_pkg;
  localparam logic [3:0] PH_LAST = 4'hB;
  localparam logic [3:0] PH_STATE_TWO_PHASE_TWO = 4'h3;
  localparam logic [3:0] PH_POLL = 4'h7;
  localparam logic [3:0] PH_STATE_FIVE_PHASE_TWO = 4'h9;
  localparam logic [3:0] PH_SNAP = 4'hA;
  localparam logic [4:0] RST_PORT_DLY = 5'h13;
  localparam logic [1:0] CALL_MC = 2'h2;
  localparam int OSC_START_MS = 10;
  localparam int CLK_KHZ = 10000;
  localparam int OSC_START_CYC = OSC_START_MS * CLK_KHZ;
  localparam logic [7:0] PORT_LATCH_RST = 8'hFF;
  localparam logic [7:0] STACK_PTR_RST = 8'h07;
  localparam logic [7:0] ADDR_PWR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_INT_ENABLE = 8'h01;
  localparam logic [7:0] ADDR_INT_PRIO = 8'h02;
  localparam logic [7:0] ADDR_EXT_MODE = 8'h03;
  localparam logic [7:0] ADDR_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h05;
  localparam int PWR_IDLE_BIT = 0;
  localparam int PWR_PD_BIT = 1;
  localparam int PWR_GFA_BIT = 2;
  localparam int PWR_GFB_BIT = 3;
  localparam int IE_GLOBAL_BIT = 7;
  localparam int NSRC = 6;
  localparam int NFLAG = 8;
  typedef enum logic [3:0] {
    PM_RUN = 4'b0001,
    PM_IDLE = 4'b0010,
    PM_PDOWN = 4'b0100,
    PM_WAKE = 4'b1000
  } rpd_pmode_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rpd_bus_t;
  typedef struct packed {
    logic [7:0] port_latch;
    logic [7:0] stack_ptr;
  } rpd_rstval_t;
endpackage

/* hw/rpd_ctrl.sv */
/*
  Interrupt response timing, reset sequencing and idle / power-down
  control. i_sys_clk is the oscillator; a machine cycle is twelve of its
  periods. The CPU core reports final-cycle, return and strobe levels on
  the same clock; pins arrive asynchronously.
*/
`timescale 1ns/1ns
module rpd_ctrl
  import rpd_pkg::*;
#(
  parameter int OSC_START_CYCLES = OSC_START_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire rpd_bus_t i_bus,
  output logic [7:0] o_rdata,
  input wire logic i_reset_pin,
  input wire logic i_ext_request_pin0,
  input wire logic i_ext_request_pin1,
  input wire logic i_timer_a_ovf,
  input wire logic i_timer_b_ovf,
  input wire logic i_timer_c_ovf,
  input wire logic i_timer_c_ext,
  input wire logic i_serial_rx,
  input wire logic i_serial_tx,
  input wire logic i_cpu_last_cycle,
  input wire logic i_cpu_return_from_interrupt,
  input wire logic i_cpu_ale,
  input wire logic i_cpu_program_store_strobe,
  output logic o_call_pulse,
  output logic [2:0] o_call_src,
  output logic o_call_busy,
  output logic o_cpu_clk_en,
  output logic o_periph_clk_en,
  output logic o_osc_run,
  output logic o_internal_reset,
  output rpd_rstval_t o_rst_vals,
  output logic o_ram_block,
  output logic o_port_hold,
  output logic o_addr_latch_strobe,
  output logic o_program_store_strobe
);

  localparam int OW = $clog2(OSC_START_CYCLES + 1);

  if (OSC_START_CYCLES < 1) begin : g_chk
    $error("OSC_START_CYCLES must be at least one");
  end

  rpd_pmode_t pmode;
  rpd_pmode_t next_pmode;
  logic [3:0] phase;
  logic osc_on;
  logic at_state_five_phase_two;
  logic at_state_two_phase_two;
  logic at_poll;
  logic at_snap;
  logic at_last;
  logic [1:0] rst_sync;
  logic [1:0] ext0_sync;
  logic [1:0] ext1_sync;
  logic rst_pin_s;
  logic ext0_s;
  logic ext1_s;
  logic rst_smp;
  logic ext0_smp;
  logic ext1_smp;
  logic dly_run;
  logic [4:0] dly_cnt;
  logic int_rst;
  logic [OW-1:0] osc_cnt;
  logic [NFLAG-1:0] flags;
  logic [NFLAG-1:0] ev_pend;
  logic [NFLAG-1:0] ev_in;
  logic [NFLAG-1:0] set_vec;
  logic [NFLAG-1:0] lvl_load;
  logic [NFLAG-1:0] lvl_val;
  logic [NFLAG-1:0] clr_vec;
  logic [NSRC-1:0] src_live;
  logic [NSRC-1:0] snap;
  logic [NSRC-1:0] req;
  logic [NSRC-1:0] req_hi;
  logic [NSRC-1:0] req_lo;
  logic [7:0] int_en;
  logic [NSRC-1:0] int_prio;
  logic [1:0] ext_mode;
  logic gf_a;
  logic gf_b;
  logic [1:0] in_prog;
  logic [1:0] call_cnt;
  logic return_from_interrupt_seen;
  logic ieip_seen;
  logic take_call;
  logic take_hi;
  logic [2:0] pick_src;
  logic wr_pwr;
  logic wr_ieip;

  function automatic logic [2:0] first_src(input logic [NSRC-1:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // Oscillator stopped or restarting freezes the machine cycle
  assign osc_on = (pmode == PM_RUN) || (pmode == PM_IDLE);
  assign at_state_five_phase_two = osc_on && (phase == PH_STATE_FIVE_PHASE_TWO);
  assign at_state_two_phase_two = osc_on && (phase == PH_STATE_TWO_PHASE_TWO);
  assign at_poll = osc_on && (phase == PH_POLL);
  assign at_snap = osc_on && (phase == PH_SNAP);
  assign at_last = osc_on && (phase == PH_LAST);

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      phase <= 4'h0;
    end else if (osc_on) begin
      phase <= (phase == PH_LAST) ? 4'h0 : phase + 4'h1;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rst_sync <= 2'b00;
      ext0_sync <= 2'b11;
      ext1_sync <= 2'b11;
    end else begin
      rst_sync <= {rst_sync[0], i_reset_pin};
      ext0_sync <= {ext0_sync[0], i_ext_request_pin0};
      ext1_sync <= {ext1_sync[0], i_ext_request_pin1};
    end
  end
  assign rst_pin_s = rst_sync[1];
  assign ext0_s = ext0_sync[1];
  assign ext1_s = ext1_sync[1];

  // Reset pin sampled once per machine cycle
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rst_smp <= 1'b0;
      ext0_smp <= 1'b1;
      ext1_smp <= 1'b1;
    end else if (at_state_five_phase_two) begin
      rst_smp <= rst_pin_s;
      ext0_smp <= ext0_s;
      ext1_smp <= ext1_s;
    end
  end

  // Ports keep running for 19 periods before internal reset takes over
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      dly_run <= 1'b0;
      dly_cnt <= 5'h00;
      int_rst <= 1'b0;
    end else if (at_state_five_phase_two && !rst_pin_s) begin
      dly_run <= 1'b0;
      int_rst <= 1'b0;
    end else if (at_state_five_phase_two && rst_pin_s && !int_rst && !dly_run) begin
      dly_run <= 1'b1;
      dly_cnt <= RST_PORT_DLY - 5'h01;
    end else if (dly_run) begin
      if (dly_cnt == 5'h00) begin
        dly_run <= 1'b0;
        int_rst <= 1'b1;
      end else begin
        dly_cnt <= dly_cnt - 5'h01;
      end
    end
  end

  // Flag set and clear terms
  assign ev_in = {i_timer_c_ext, i_timer_c_ovf, i_serial_tx, i_serial_rx,
                  i_timer_b_ovf, 1'b0, i_timer_a_ovf, 1'b0};

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ev_pend <= '0;
    end else begin
      for (int i = 0; i < NFLAG; i++) begin
        if (ev_in[i]) begin
          ev_pend[i] <= 1'b1;
        end else if ((i == 6) ? at_state_two_phase_two : at_state_five_phase_two) begin
          ev_pend[i] <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    set_vec = '0;
    lvl_load = '0;
    lvl_val = '0;
    clr_vec = '0;
    set_vec[1] = at_state_five_phase_two && (ev_pend[1] || ev_in[1]);
    set_vec[3] = at_state_five_phase_two && (ev_pend[3] || ev_in[3]);
    set_vec[4] = at_state_five_phase_two && (ev_pend[4] || ev_in[4]);
    set_vec[5] = at_state_five_phase_two && (ev_pend[5] || ev_in[5]);
    set_vec[7] = at_state_five_phase_two && (ev_pend[7] || ev_in[7]);
    set_vec[6] = at_state_two_phase_two && (ev_pend[6] || ev_in[6]);
    // Level mode follows the inverted pin, transition mode catches falls
    lvl_load[0] = at_state_five_phase_two && !ext_mode[0];
    lvl_val[0] = !ext0_s;
    lvl_load[2] = at_state_five_phase_two && !ext_mode[1];
    lvl_val[2] = !ext1_s;
    set_vec[0] = at_state_five_phase_two && ext_mode[0] && ext0_smp && !ext0_s;
    set_vec[2] = at_state_five_phase_two && ext_mode[1] && ext1_smp && !ext1_s;
    if (take_call) begin
      clr_vec[1] = (pick_src == 3'h1);
      clr_vec[3] = (pick_src == 3'h3);
      clr_vec[0] = (pick_src == 3'h0) && ext_mode[0];
      clr_vec[2] = (pick_src == 3'h2) && ext_mode[1];
    end
    if (i_bus.wr && (i_bus.addr == ADDR_FLAGS)) begin
      clr_vec = clr_vec | i_bus.wdata;
    end
  end

  // Set wins over call and write clears in the same cycle; internal reset wins over set
  for (genvar g = 0; g < NFLAG; g++) begin : g_flag
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
        flags[g] <= 1'b0;
      end else if (int_rst) begin
        flags[g] <= 1'b0;
      end else if (set_vec[g]) begin
        flags[g] <= 1'b1;
      end else if (lvl_load[g]) begin
        flags[g] <= lvl_val[g];
      end else if (clr_vec[g]) begin
        flags[g] <= 1'b0;
      end
    end
  end

  assign src_live = {flags[7] | flags[6], flags[5] | flags[4],
                     flags[3], flags[2], flags[1], flags[0]};

  // Samples taken at phase ten are the ones polled next cycle
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      snap <= '0;
    end else if (at_snap) begin
      snap <= src_live;
    end
  end

  // Timer C source polled live: overflow flag set at phase three of this cycle
  assign req = {src_live[5], snap[4:0]} & int_en[NSRC-1:0]
               & {NSRC{int_en[IE_GLOBAL_BIT]}};
  assign req_hi = req & int_prio;
  assign req_lo = req & ~int_prio;
  assign wr_pwr = i_bus.wr && (i_bus.addr == ADDR_PWR_CTRL);
  assign wr_ieip = i_bus.wr && ((i_bus.addr == ADDR_INT_ENABLE) ||
                                (i_bus.addr == ADDR_INT_PRIO));

  always_comb begin
    take_hi = (|req_hi) && !in_prog[1];
    take_call = at_poll && (o_call_busy == 1'b0)
                && ((pmode == PM_IDLE) || i_cpu_last_cycle)
                && !return_from_interrupt_seen && !ieip_seen && !i_cpu_return_from_interrupt
                && !wr_ieip
                && (take_hi || ((|req_lo) && (in_prog == 2'b00)));
    pick_src = take_hi ? first_src(req_hi) : first_src(req_lo);
  end

  // Return or IE/IP write blocks the next poll
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      return_from_interrupt_seen <= 1'b0;
      ieip_seen <= 1'b0;
    end else if (int_rst) begin
      return_from_interrupt_seen <= 1'b0;
      ieip_seen <= 1'b0;
    end else begin
      if (i_cpu_return_from_interrupt) begin
        return_from_interrupt_seen <= 1'b1;
      end else if (at_poll) begin
        return_from_interrupt_seen <= 1'b0;
      end
      if (wr_ieip) begin
        ieip_seen <= 1'b1;
      end else if (at_poll) begin
        ieip_seen <= 1'b0;
      end
    end
  end

  // Levels in service; return releases the highest one
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      in_prog <= 2'b00;
    end else if (int_rst) begin
      in_prog <= 2'b00;
    end else if (take_call) begin
      in_prog[take_hi ? 1 : 0] <= 1'b1;
    end else if (i_cpu_return_from_interrupt) begin
      if (in_prog[1]) begin
        in_prog[1] <= 1'b0;
      end else begin
        in_prog[0] <= 1'b0;
      end
    end
  end

  // Hardware call occupies two machine cycles
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      call_cnt <= 2'h0;
      o_call_busy <= 1'b0;
      o_call_pulse <= 1'b0;
      o_call_src <= 3'h0;
    end else if (int_rst) begin
      call_cnt <= 2'h0;
      o_call_busy <= 1'b0;
      o_call_pulse <= 1'b0;
    end else begin
      o_call_pulse <= take_call;
      if (take_call) begin
        o_call_src <= pick_src;
        call_cnt <= CALL_MC;
        o_call_busy <= 1'b1;
      end else if (at_last && (call_cnt != 2'h0)) begin
        call_cnt <= call_cnt - 2'h1;
        o_call_busy <= (call_cnt != 2'h1);
      end
    end
  end

  // Software registers
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      int_en <= 8'h00;
      int_prio <= '0;
      ext_mode <= 2'b00;
      gf_a <= 1'b0;
      gf_b <= 1'b0;
    end else if (int_rst) begin
      int_en <= 8'h00;
      int_prio <= '0;
      ext_mode <= 2'b00;
      gf_a <= 1'b0;
      gf_b <= 1'b0;
    end else if (i_bus.wr) begin
      case (i_bus.addr)
        ADDR_INT_ENABLE: begin
          int_en <= i_bus.wdata;
        end
        ADDR_INT_PRIO: begin
          int_prio <= i_bus.wdata[NSRC-1:0];
        end
        ADDR_EXT_MODE: begin
          ext_mode <= i_bus.wdata[1:0];
        end
        ADDR_PWR_CTRL: begin
          gf_a <= i_bus.wdata[PWR_GFA_BIT];
          gf_b <= i_bus.wdata[PWR_GFB_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // Power mode sequencing
  always_comb begin
    next_pmode = pmode;
    case (pmode)
      PM_RUN: begin
        if (wr_pwr && i_bus.wdata[PWR_PD_BIT]) begin
          next_pmode = PM_PDOWN;
        end else if (wr_pwr && i_bus.wdata[PWR_IDLE_BIT]) begin
          next_pmode = PM_IDLE;
        end
      end
      PM_IDLE: begin
        if (rst_pin_s) begin
          next_pmode = PM_RUN;
        end else if (at_poll && (|req)) begin
          next_pmode = PM_RUN;
        end
      end
      PM_PDOWN: begin
        if (rst_pin_s) begin
          next_pmode = PM_WAKE;
        end
      end
      PM_WAKE: begin
        if (osc_cnt == '0) begin
          next_pmode = PM_RUN;
        end
      end
      default: begin
        next_pmode = PM_RUN;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pmode <= PM_RUN;
    end else begin
      pmode <= next_pmode;
    end
  end

  // Oscillator restart wait after leaving power-down
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      osc_cnt <= '0;
    end else if (pmode == PM_PDOWN) begin
      osc_cnt <= OW'(OSC_START_CYCLES - 1);
    end else if ((pmode == PM_WAKE) && (osc_cnt != '0)) begin
      osc_cnt <= osc_cnt - OW'(1);
    end
  end

  // RAM access fenced from reset idle exit until internal reset
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ram_block <= 1'b0;
    end else if (int_rst) begin
      o_ram_block <= 1'b0;
    end else if ((pmode == PM_IDLE) && rst_pin_s) begin
      o_ram_block <= 1'b1;
    end
  end

  // Clock gates, strobes and pin hold
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cpu_clk_en <= 1'b1;
      o_periph_clk_en <= 1'b1;
      o_osc_run <= 1'b1;
      o_port_hold <= 1'b0;
      o_addr_latch_strobe <= 1'b1;
      o_program_store_strobe <= 1'b1;
    end else begin
      o_cpu_clk_en <= (next_pmode == PM_RUN);
      o_periph_clk_en <= (next_pmode == PM_RUN) ||
                         (next_pmode == PM_IDLE);
      o_osc_run <= (next_pmode != PM_PDOWN);
      o_port_hold <= (next_pmode != PM_RUN);
      case (next_pmode)
        PM_RUN: begin
          o_addr_latch_strobe <= i_cpu_ale;
          o_program_store_strobe <= i_cpu_program_store_strobe;
        end
        PM_IDLE: begin
          o_addr_latch_strobe <= 1'b1;
          o_program_store_strobe <= 1'b1;
        end
        default: begin
          o_addr_latch_strobe <= 1'b0;
          o_program_store_strobe <= 1'b0;
        end
      endcase
    end
  end

  // Register defaults handed to the core during internal reset
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_internal_reset <= 1'b0;
      o_rst_vals <= '0;
    end else begin
      o_internal_reset <= int_rst;
      if (int_rst) begin
        o_rst_vals.port_latch <= PORT_LATCH_RST;
        o_rst_vals.stack_ptr <= STACK_PTR_RST;
      end else begin
        o_rst_vals <= '0;
      end
    end
  end

  // Read data in the cycle after the strobe
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_bus.rd) begin
      case (i_bus.addr)
        ADDR_PWR_CTRL: begin
          o_rdata <= {4'h0, gf_b, gf_a, pmode == PM_PDOWN,
                      pmode == PM_IDLE};
        end
        ADDR_INT_ENABLE: begin
          o_rdata <= int_en;
        end
        ADDR_INT_PRIO: begin
          o_rdata <= {2'b00, int_prio};
        end
        ADDR_EXT_MODE: begin
          o_rdata <= {6'h00, ext_mode};
        end
        ADDR_FLAGS: begin
          o_rdata <= flags;
        end
        ADDR_STATUS: begin
          o_rdata <= {int_rst, o_call_busy, in_prog, pmode == PM_WAKE,
                      o_ram_block, return_from_interrupt_seen, ieip_seen};
        end
        default: begin
          o_rdata <= 8'h00;
        end
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

endmodule // rpd_ctrl

/* tb/rpd_ctrl_assertions.sv */
/*
  Port-level timing checks for rpd_ctrl.
  Bound to every rpd_ctrl instance; one clock, i_sys_clk.
*/
`timescale 1ns/1ns
module rpd_checker
  import rpd_pkg::*;
#(
  parameter int OSC_START_CYCLES = OSC_START_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire rpd_bus_t i_bus,
  input wire logic [7:0] o_rdata,
  input wire logic i_reset_pin,
  input wire logic i_cpu_last_cycle,
  input wire logic o_call_pulse,
  input wire logic o_call_busy,
  input wire logic o_cpu_clk_en,
  input wire logic o_periph_clk_en,
  input wire logic o_osc_run,
  input wire logic o_internal_reset,
  input wire rpd_rstval_t o_rst_vals,
  input wire logic o_port_hold,
  input wire logic o_addr_latch_strobe,
  input wire logic o_program_store_strobe
);
  logic [5:0] pin_cnt;
  logic idle_now;
  assign idle_now = !o_cpu_clk_en && o_periph_clk_en;
  // Consecutive cycles of reset pin high with the oscillator running
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_cnt <= 6'h00;
    end else if (!i_reset_pin || !o_osc_run) begin
      pin_cnt <= 6'h00;
    end else if (pin_cnt != 6'h3F) begin
      pin_cnt <= pin_cnt + 6'h01;
    end
  end
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  sequence s_idle_pin;
    idle_now && i_reset_pin ##1 i_reset_pin[*3];
  endsequence
  sequence s_pd_quiet;
    !i_reset_pin[*4] ##0 !o_osc_run;
  endsequence
  a_call_sets_busy: assert property (
    o_call_pulse |-> o_call_busy) else $error("call without busy");
  a_no_call_busy: assert property (
    o_call_pulse |-> !$past(o_call_busy)) else $error("call while busy");
  a_call_last_cycle: assert property (
    o_call_pulse && $past(o_cpu_clk_en, 2) |-> $past(i_cpu_last_cycle))
    else $error("call in non-final cycle");
  a_idle_holds: assert property (
    idle_now |-> o_addr_latch_strobe && o_program_store_strobe
      && o_port_hold) else $error("idle outputs wrong");
  a_pd_outputs: assert property (
    !o_osc_run |-> !o_addr_latch_strobe && !o_program_store_strobe
      && o_port_hold && !o_cpu_clk_en) else $error("pd outputs wrong");
  a_rst_values: assert property (
    $rose(o_internal_reset) |->
      o_rst_vals == {PORT_LATCH_RST, STACK_PTR_RST} ##1
      o_rst_vals == {PORT_LATCH_RST, STACK_PTR_RST})
    else $error("reset values wrong");
  a_rst_min_hold: assert property (
    $rose(o_internal_reset) |-> pin_cnt >= 6'h13)
    else $error("internal reset too early");
  a_idle_pin_exit: assert property (
    s_idle_pin |-> ##[0:2] o_cpu_clk_en) else $error("idle kept on pin");
  a_pd_stays: assert property (
    s_pd_quiet |=> !o_osc_run) else $error("pd left without pin");
  a_wake_time: assert property (
    $rose(o_osc_run) |-> !o_cpu_clk_en[*8] ##[1:40] o_cpu_clk_en)
    else $error("wake length wrong");
  a_rdata_quiet: assert property (
    !$past(i_bus.rd) |-> o_rdata == 8'h00) else $error("stray rdata");
endmodule // rpd_checker

bind rpd_ctrl rpd_checker #(.OSC_START_CYCLES(OSC_START_CYCLES)) chk_u (
  .i_sys_clk, .i_rst, .i_bus, .o_rdata, .i_reset_pin, .i_cpu_last_cycle,
  .o_call_pulse, .o_call_busy, .o_cpu_clk_en, .o_periph_clk_en,
  .o_osc_run, .o_internal_reset, .o_rst_vals, .o_port_hold,
  .o_addr_latch_strobe, .o_program_store_strobe);

/* tb/rpd_partner.sv */
/*
  Model of the outside reset circuit and external request pins.
  Drives its pins just after rising edges of i_sys_clk.
*/
`timescale 1ns/1ns
module rpd_partner (
  input wire logic i_sys_clk,
  output logic o_reset_pin,
  output logic o_req_pin0,
  output logic o_req_pin1
);
  initial begin
    o_reset_pin = 1'b0;
    o_req_pin0 = 1'b1;
    o_req_pin1 = 1'b1;
  end
  // Callers hold at least two machine cycles, longer after power-down
  task automatic hold_reset(input int n);
    @(posedge i_sys_clk);
    o_reset_pin <= 1'b1;
    repeat (n) @(posedge i_sys_clk);
    o_reset_pin <= 1'b0;
  endtask
  task automatic set_req0(input logic v);
    @(posedge i_sys_clk);
    o_req_pin0 <= v;
  endtask
endmodule // rpd_partner

/* tb/tb_rpd_ctrl.sv */
/*
  Testbench for rpd_ctrl: registers, interrupt timing, idle, power-down
  and reset. Assumes rpd_partner drives the pins.
*/
`timescale 1ns/1ns
module tb_rpd_ctrl
  import rpd_pkg::*;
;
  logic i_sys_clk, i_rst, i_reset_pin;
  logic i_ext_request_pin0, i_ext_request_pin1;
  logic i_cpu_last_cycle, i_cpu_return_from_interrupt, i_cpu_ale, i_cpu_program_store_strobe;
  logic o_call_pulse, o_call_busy, o_cpu_clk_en, o_periph_clk_en;
  logic o_osc_run, o_internal_reset, o_ram_block, o_port_hold;
  logic o_addr_latch_strobe, o_program_store_strobe;
  logic [2:0] o_call_src;
  logic [7:0] o_rdata, v;
  logic [5:0] ev;
  rpd_bus_t i_bus;
  rpd_rstval_t o_rst_vals;
  logic [2:0] srcs [6] = '{3'h1, 3'h3, 3'h4, 3'h4, 3'h5, 3'h5};
  int n_mismatch, compares, lat, t_clk, t_blk, t_rst;
  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  rpd_ctrl #(.OSC_START_CYCLES(16)) dut_u (
    .i_sys_clk, .i_rst, .i_bus, .o_rdata, .i_reset_pin,
    .i_ext_request_pin0, .i_ext_request_pin1,
    .i_timer_a_ovf(ev[0]), .i_timer_b_ovf(ev[1]), .i_serial_rx(ev[2]),
    .i_serial_tx(ev[3]), .i_timer_c_ovf(ev[4]), .i_timer_c_ext(ev[5]),
    .i_cpu_last_cycle, .i_cpu_return_from_interrupt, .i_cpu_ale, .i_cpu_program_store_strobe,
    .o_call_pulse, .o_call_src, .o_call_busy, .o_cpu_clk_en,
    .o_periph_clk_en, .o_osc_run, .o_internal_reset, .o_rst_vals,
    .o_ram_block, .o_port_hold, .o_addr_latch_strobe,
    .o_program_store_strobe);
  rpd_partner pin_u (.i_sys_clk, .o_reset_pin(i_reset_pin),
    .o_req_pin0(i_ext_request_pin0), .o_req_pin1(i_ext_request_pin1));
  task summarize;
    if (n_mismatch == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t byte %h not %h", $time, got, exp);
    end
  endtask
  task chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t bit %b not %b", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask
  task bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_bus <= '{a, d, 1'b1, 1'b0};
    @(posedge i_sys_clk);
    i_bus.wr <= 1'b0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_sys_clk);
    i_bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge i_sys_clk);
    i_bus.rd <= 1'b0;
    @(negedge i_sys_clk);
    chk8(o_rdata, exp);
  endtask
  task fire(input int k);
    @(posedge i_sys_clk);
    ev <= 6'h01 << k;
    @(posedge i_sys_clk);
    ev <= 6'h00;
  endtask
  task pulse_return_from_interrupt;
    @(posedge i_sys_clk);
    i_cpu_return_from_interrupt <= 1'b1;
    @(posedge i_sys_clk);
    i_cpu_return_from_interrupt <= 1'b0;
  endtask
  task wait_call(input int lim, output int n);
    n = 0;
    do begin
      @(negedge i_sys_clk);
      n++;
      if (n > lim) begin
        n_mismatch++;
        $display("[FAIL] %0t no call", $time);
        summarize();
      end
    end while (o_call_pulse !== 1'b1);
  endtask
  task quiet(input int lim);
    repeat (lim) begin
      @(negedge i_sys_clk);
      chk1(o_call_pulse, 1'b0);
    end
  endtask
  initial begin
    i_rst = 1'b1;
    i_bus = '0;
    ev = 6'h00;
    i_cpu_last_cycle = 1'b1;
    i_cpu_return_from_interrupt = 1'b0;
    i_cpu_ale = 1'b0;
    i_cpu_program_store_strobe = 1'b0;
    n_mismatch = 0;
    compares = 0;
    tick(20);
    i_rst <= 1'b0;
    for (int a = 0; a < 8; a++) rd_chk(a[7:0], 8'h00);
    bus_wr(ADDR_PWR_CTRL, 8'h0C);
    rd_chk(ADDR_PWR_CTRL, 8'h0C);
    bus_wr(ADDR_PWR_CTRL, 8'h00);
    bus_wr(ADDR_INT_ENABLE, 8'hBF);
    i_cpu_last_cycle <= 1'b0;
    fire(0);
    quiet(40);
    i_cpu_last_cycle <= 1'b1;
    wait_call(30, lat);
    chk8({5'h00, o_call_src}, 8'h01);
    pulse_return_from_interrupt();
    tick(30);
    for (int k = 0; k < 6; k++) begin
      fire(k);
      wait_call(40, lat);
      chk8({5'h00, o_call_src}, {5'h00, srcs[k]});
      chk1(k == 4 ? lat <= 17 : lat >= 11, 1'b1);
      bus_wr(ADDR_FLAGS, 8'hFF);
      pulse_return_from_interrupt();
      tick(30);
    end
    pin_u.set_req0(1'b0);
    wait_call(40, lat);
    chk8({5'h00, o_call_src}, 8'h00);
    chk1(lat >= 13 && lat <= 26, 1'b1);
    quiet(30);
    pulse_return_from_interrupt();
    wait_call(40, lat);
    chk1(lat >= 12, 1'b1);
    pin_u.set_req0(1'b1);
    tick(30);
    pulse_return_from_interrupt();
    tick(30);
    bus_wr(ADDR_EXT_MODE, 8'h01);
    pin_u.set_req0(1'b0);
    wait_call(40, lat);
    chk8({5'h00, o_call_src}, 8'h00);
    rd_chk(ADDR_FLAGS, 8'h00);
    pulse_return_from_interrupt();
    quiet(40);
    pin_u.set_req0(1'b1);
    tick(4);
    bus_wr(ADDR_EXT_MODE, 8'h00);
    tick(30);
    bus_wr(ADDR_PWR_CTRL, 8'h05);
    tick(1);
    @(negedge i_sys_clk);
    chk1(o_cpu_clk_en, 1'b0);
    chk1(o_periph_clk_en, 1'b1);
    chk1(o_addr_latch_strobe & o_program_store_strobe, 1'b1);
    chk1(o_port_hold, 1'b1);
    fire(1);
    wait_call(40, lat);
    chk8({5'h00, o_call_src}, 8'h03);
    tick(2);
    chk1(o_cpu_clk_en, 1'b1);
    rd_chk(ADDR_PWR_CTRL, 8'h04);
    pulse_return_from_interrupt();
    tick(30);
    i_cpu_ale <= 1'b1;
    i_cpu_program_store_strobe <= 1'b1;
    bus_wr(ADDR_PWR_CTRL, 8'h03);
    tick(1);
    @(negedge i_sys_clk);
    chk1(o_osc_run, 1'b0);
    chk1(o_periph_clk_en, 1'b0);
    chk1(o_addr_latch_strobe | o_program_store_strobe, 1'b0);
    chk1(o_port_hold, 1'b1);
    fire(0);
    quiet(30);
    chk1(o_osc_run, 1'b0);
    pin_u.hold_reset(60);
    tick(20);
    chk1(o_osc_run & o_cpu_clk_en, 1'b1);
    rd_chk(ADDR_INT_ENABLE, 8'h00);
    bus_wr(ADDR_PWR_CTRL, 8'h01);
    tick(3);
    t_clk = -1;
    t_blk = -1;
    t_rst = -1;
    fork
      pin_u.hold_reset(45);
      for (int i = 1; i <= 44; i++) begin
        @(negedge i_sys_clk);
        if (t_clk < 0 && o_cpu_clk_en === 1'b1) t_clk = i;
        if (t_blk < 0 && o_ram_block === 1'b1) t_blk = i;
        if (t_rst < 0 && o_internal_reset === 1'b1) t_rst = i;
      end
    join
    chk1(t_clk > 0 && t_clk <= 7, 1'b1);
    chk1(t_blk > 0 && t_blk < t_rst, 1'b1);
    chk1(t_rst >= 21 && t_rst <= 38, 1'b1);
    chk8(o_rst_vals.port_latch, 8'hFF);
    chk8(o_rst_vals.stack_ptr, 8'h07);
    tick(30);
    rd_chk(ADDR_PWR_CTRL, 8'h00);
    summarize();
  end
endmodule // tb_rpd_ctrl
